// *** srm_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the routing matrix.
// Assumes byte addresses on a 32-bit APB bus, one aligned word per register.
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

`define SRM_OFF_VIN      8'h00
`define SRM_OFF_FKEY     8'h04
`define SRM_OFF_LATCH    8'h08
`define SRM_OFF_RELEASE  8'h0C
`define SRM_OFF_AUTO     8'h10
`define SRM_OFF_STATE    8'h14
`define SRM_OFF_RAW      8'h18
`define SRM_OFF_MTX      8'h40

`define SRM_VIN_N        4
`define SRM_DEST_N       22
`define SRM_SRC_N        16
`define SRM_LED_LO       5
`define SRM_LED_N        10

`define SRM_FKEY_RST     32'h0000_0010
`define SRM_FKEY_IDX0    0
`define SRM_FKEY_OBJ0    2
`define SRM_FKEY_IDX1    4
`define SRM_FKEY_OBJ1    6
`define SRM_AUTO_EN      0
`define SRM_AUTO_DLY_LO  16
`define SRM_AGE_MS_RST   16'h05DC

`define SRM_CLK_NS       20
`define SRM_MS_NS        1000000
`define SRM_MS_CYCLES    (`SRM_MS_NS / `SRM_CLK_NS)

`endif

// *** srm_pkg.sv ***
// Types shared by the routing matrix and its bench.
// Assumes srm_regs.svh for the widths.
`include "srm_regs.svh"
package srm_pkg;
  typedef struct packed {
    logic [5:0] virtual_output;
    logic       disturbance_recorder_trigger;
    logic [1:0] key_led;
    logic [7:0] indicator_led;
    logic       alarm_relay_one;
    logic [3:0] trip_relay;
  } srm_dest_s;

  typedef struct packed {
    logic                     we;
    logic [`SRM_VIN_N-1:0]    mask;
    logic [`SRM_VIN_N-1:0]    value;
  } srm_vin_wr_s;
endpackage

// *** srm_matrix.sv ***
// Signal routing matrix with latches, virtual inputs, function keys and stale LED autoclear.
// Assumes APB master on pclk, all other inputs synchronous to pclk.
// Summary of operation
// R1: Four virtual input bits live in flops and feed the matrix like digital inputs.
// R2: Virtual inputs are written from the panel port, the comm bus port and APB.
// R3: Six virtual outputs are matrix columns that drive no contact.
// R4: Virtual output states leave the block for logic and setting group selection.
// R5: After reset the first key toggles virtual input one and the second virtual input two.
// R6: Each key can be remapped to another virtual input or to an object control command.
// R7: Any source may be routed to any destination through a per-destination source mask.
// R8: Eight indicator LEDs A to H are matrix destinations.
// R9: Two key LEDs, a recorder trigger and the virtual outputs are also destinations.
// R10: A non-latched destination follows its routed signal.
// R11: A latched destination stays on after its signal drops until released.
// R12: With autoclear on, a new event clears latched LEDs already classed as old.
// R13: A latched LED becomes old only after the age delay since its signal dropped.
// R14: A key toggles its virtual input once per press edge.
// R15: Software or the panel may release all latches by command.
`timescale 1ns/1ns
`include "srm_regs.svh"
module srm_matrix #(
  parameter int MS_CYCLES = `SRM_MS_CYCLES,
  parameter int SRC_W     = `SRM_SRC_N
) (
  input  wire logic                    pclk,                  // 50 MHz clock
  input  wire logic                    presetn,               // Async reset, active low
  input  wire logic                    psel,                  // APB select
  input  wire logic                    penable,               // APB enable
  input  wire logic                    pwrite,                // APB direction
  input  wire logic [7:0]              paddr,                 // APB byte address
  input  wire logic [31:0]             pwdata,                // APB write data
  output logic      [31:0]             prdata,                // APB read data
  output logic                         pready,                // APB ready
  output logic                         pslverr,               // APB error on unmapped
  input  wire logic [SRC_W-`SRM_VIN_N-1:0] ext_src,           // Stage, DI and logic signals
  input  wire srm_pkg::srm_vin_wr_s    panel_vin_wr,          // Panel write of virtual inputs
  input  wire srm_pkg::srm_vin_wr_s    bus_vin_wr,            // Comm bus write of virtual inputs
  input  wire logic                    first_function_key,    // Key one level
  input  wire logic                    second_function_key,   // Key two level
  input  wire logic                    panel_release,         // Panel latch release pulse
  output srm_pkg::srm_dest_s           dest,                  // Relays, LEDs, recorder, outputs
  output logic [`SRM_VIN_N-1:0]        virtual_input,         // Virtual input states
  output logic [1:0]                   obj_cmd                // Object control pulses per key
);
  import srm_pkg::*;

  localparam int DN = `SRM_DEST_N;
  localparam int LN = `SRM_LED_N;

  logic [`SRM_VIN_N-1:0] vin_q, vin_d;
  logic [31:0]           fkey_q, fkey_d;
  logic [DN-1:0]         latch_q, latch_d;
  logic                  auto_en_q, auto_en_d;
  logic [15:0]           age_dly_q, age_dly_d;
  logic [SRC_W-1:0]      mtx_q [DN];
  logic [SRC_W-1:0]      mtx_d [DN];
  logic [DN-1:0]         dest_q, dest_d, raw, raw_q;
  logic [1:0]            key_q, key_rise;
  logic [1:0]            obj_q, obj_d;
  logic                  pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0]           prdata_q, prdata_d;
  logic [31:0]           tick_cnt_q, tick_cnt_d;
  logic                  tick;
  logic [15:0]           age_q [LN];
  logic [15:0]           age_d [LN];
  logic [LN-1:0]         old_v;
  logic                  new_evt, rel_any, apb_wr, vin_wr_any;
  logic [DN-1:0]         auto_clr;
  logic [SRC_W-1:0]      src;
  logic [5:0]            widx;

  // APB: one wait state so read data leaves a flop
  assign apb_wr = psel & penable & pready_q & pwrite;
  assign widx   = paddr[7:2] - 6'(`SRM_OFF_MTX >> 2);

  assign src     = {ext_src, vin_q};                                // R1
  assign key_rise = {second_function_key, first_function_key} & ~key_q; // R14
  assign rel_any = panel_release | (apb_wr & paddr == `SRM_OFF_RELEASE & pwdata[0]); // R15
  assign tick    = tick_cnt_q == 32'(MS_CYCLES - 1);

  always_comb begin
    for (int d = 0; d < DN; d++) begin
      raw[d] = |(mtx_q[d] & src);                                   // R7
    end
  end

  // New event: any LED column picking up a fresh drive
  assign new_evt = |(raw[`SRM_LED_LO +: LN] & ~raw_q[`SRM_LED_LO +: LN]);

  always_comb begin
    for (int i = 0; i < LN; i++) begin
      old_v[i] = dest_q[`SRM_LED_LO + i] & latch_q[`SRM_LED_LO + i] &
                 ~raw_q[`SRM_LED_LO + i] & (age_q[i] >= age_dly_q);  // R13
    end
  end

  always_comb begin
    auto_clr = '0;
    if (auto_en_q && new_evt) begin
      auto_clr[`SRM_LED_LO +: LN] = old_v;                          // R12
    end
  end

  // Apply order: APB, then comm bus, then panel; key toggle last
  assign vin_wr_any = (apb_wr & paddr == `SRM_OFF_VIN) | bus_vin_wr.we | panel_vin_wr.we;

  always_comb begin
    vin_d = vin_q;
    if (apb_wr && paddr == `SRM_OFF_VIN) begin
      vin_d = pwdata[`SRM_VIN_N-1:0];                               // R2
    end
    if (bus_vin_wr.we) begin
      vin_d = (vin_d & ~bus_vin_wr.mask) | (bus_vin_wr.value & bus_vin_wr.mask); // R2
    end
    if (panel_vin_wr.we) begin
      vin_d = (vin_d & ~panel_vin_wr.mask) | (panel_vin_wr.value & panel_vin_wr.mask); // R2
    end
    obj_d = '0;
    if (key_rise[0]) begin
      if (fkey_q[`SRM_FKEY_OBJ0]) obj_d[0] = 1'b1;                  // R6
      else vin_d[fkey_q[`SRM_FKEY_IDX0 +: 2]] = ~vin_d[fkey_q[`SRM_FKEY_IDX0 +: 2]]; // R5
    end
    if (key_rise[1]) begin
      if (fkey_q[`SRM_FKEY_OBJ1]) obj_d[1] = 1'b1;                  // R6
      else vin_d[fkey_q[`SRM_FKEY_IDX1 +: 2]] = ~vin_d[fkey_q[`SRM_FKEY_IDX1 +: 2]]; // R5
    end
  end

  // Config registers and read path
  always_comb begin
    fkey_d    = fkey_q;
    latch_d   = latch_q;
    auto_en_d = auto_en_q;
    age_dly_d = age_dly_q;
    for (int d = 0; d < DN; d++) mtx_d[d] = mtx_q[d];
    if (apb_wr) begin
      case (paddr)
        `SRM_OFF_FKEY:  fkey_d = pwdata & 32'h0000_0077;            // R6
        `SRM_OFF_LATCH: latch_d = pwdata[DN-1:0];                   // R10
        `SRM_OFF_AUTO: begin
          auto_en_d = pwdata[`SRM_AUTO_EN];
          age_dly_d = pwdata[`SRM_AUTO_DLY_LO +: 16];
        end
        default: begin
          if (paddr[1:0] == 2'h0 && paddr >= `SRM_OFF_MTX && widx < 6'(DN)) begin
            mtx_d[widx[4:0]] = pwdata[SRC_W-1:0];                    // R7
          end
        end
      endcase
    end
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (psel && penable && !pready_q) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `SRM_OFF_VIN:     prdata_d[`SRM_VIN_N-1:0] = vin_q;
        `SRM_OFF_FKEY:    prdata_d = fkey_q;
        `SRM_OFF_LATCH:   prdata_d[DN-1:0] = latch_q;
        `SRM_OFF_RELEASE: prdata_d = 32'h0000_0000;
        `SRM_OFF_AUTO:    prdata_d = {age_dly_q, 15'h0000, auto_en_q};
        `SRM_OFF_STATE:   prdata_d[DN-1:0] = dest_q;
        `SRM_OFF_RAW:     prdata_d[DN-1:0] = raw_q;
        default: begin
          if (paddr[1:0] == 2'h0 && paddr >= `SRM_OFF_MTX && widx < 6'(DN)) begin
            prdata_d[SRC_W-1:0] = mtx_q[widx[4:0]];
          end else begin
            pslverr_d = 1'b1;
          end
        end
      endcase
      if (pwrite) prdata_d = prdata_q;
      if (pwrite && (paddr == `SRM_OFF_STATE || paddr == `SRM_OFF_RAW)) pslverr_d = 1'b1;
    end
  end

  // Destination state and LED age counters
  always_comb begin
    tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    for (int d = 0; d < DN; d++) begin
      if (rel_any) begin
        dest_d[d] = raw[d];                                         // R15
      end else if (auto_clr[d]) begin
        dest_d[d] = raw[d];                                         // R12
      end else begin
        dest_d[d] = raw[d] | (dest_q[d] & latch_q[d]);              // R10 R11
      end
    end
    for (int i = 0; i < LN; i++) begin
      age_d[i] = age_q[i];
      if (!dest_q[`SRM_LED_LO + i] || raw_q[`SRM_LED_LO + i]) begin
        age_d[i] = 16'h0000;                                        // R13
      end else if (tick && age_q[i] < age_dly_q) begin
        // Saturates at the delay, so a shortened delay cannot wrap the count
        age_d[i] = age_q[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vin_q      <= '0;
      fkey_q     <= `SRM_FKEY_RST;                                  // R5
      latch_q    <= '0;
      auto_en_q  <= 1'b0;
      age_dly_q  <= `SRM_AGE_MS_RST;
      dest_q     <= '0;
      raw_q      <= '0;
      key_q      <= 2'h0;
      obj_q      <= 2'h0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      tick_cnt_q <= 32'h0000_0000;
      for (int d = 0; d < DN; d++) mtx_q[d] <= '0;
      for (int i = 0; i < LN; i++) age_q[i] <= 16'h0000;
    end else begin
      vin_q      <= vin_d;
      fkey_q     <= fkey_d;
      latch_q    <= latch_d;
      auto_en_q  <= auto_en_d;
      age_dly_q  <= age_dly_d;
      dest_q     <= dest_d;
      raw_q      <= raw;
      key_q      <= {second_function_key, first_function_key};
      obj_q      <= obj_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      tick_cnt_q <= tick_cnt_d;
      for (int d = 0; d < DN; d++) mtx_q[d] <= mtx_d[d];
      for (int i = 0; i < LN; i++) age_q[i] <= age_d[i];
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign dest          = srm_dest_s'(dest_q);                       // R3 R8 R9
  assign virtual_input = vin_q;                                     // R4
  assign obj_cmd       = obj_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_NONLATCH_FOLLOW: assert property ( // R10
    ##1 (((dest_q ^ $past(raw)) & ~$past(latch_q)) == '0))
    else $error("Non-latched destination does not follow its signal");

  AST_LATCH_HOLD: assert property ( // R11
    (!rel_any && auto_clr == '0) |=> ((($past(dest_q) & $past(latch_q)) & ~dest_q) == '0))
    else $error("Latched destination dropped without release");

  AST_RELEASE: assert property ( // R15
    rel_any |=> dest_q == $past(raw))
    else $error("Release did not return destinations to their signals");

  AST_AUTOCLR: assert property ( // R12
    (auto_en_q && new_evt && old_v != '0) |=>
      ((dest_q[`SRM_LED_LO +: LN] & $past(old_v) & ~$past(raw[`SRM_LED_LO +: LN])) == '0))
    else $error("Old latched LED survived a new event");

  AST_OLD_DELAY: assert property ( // R13
    ((old_v & ~$past(old_v)) != '0) |-> age_dly_q == 16'h0000 || $past(tick) || $changed(age_dly_q))
    else $error("LED became old without an age tick");

  AST_KEY_TOGGLE: assert property ( // R14
    (key_rise == 2'b01 && !fkey_q[`SRM_FKEY_OBJ0] && !vin_wr_any) |=>
      (vin_q != $past(vin_q)) ##1 ($stable(vin_q) || $past(vin_wr_any) || $past(key_rise[1])))
    else $error("Key press did not toggle exactly once");

  AST_OBJ_CMD: assert property ( // R6
    (key_rise[0] && fkey_q[`SRM_FKEY_OBJ0]) |=> obj_cmd[0] ##1 !obj_cmd[0])
    else $error("Object command pulse missing or too long");

  AST_VIN_WRITE: assert property ( // R2
    (apb_wr && paddr == `SRM_OFF_VIN && !bus_vin_wr.we && !panel_vin_wr.we && key_rise == 2'b00)
      |=> vin_q == $past(pwdata[`SRM_VIN_N-1:0]))
    else $error("Software write to virtual inputs lost");

  AST_KEY2_TOGGLE: assert property ( // R14
    (key_rise == 2'b10 && !fkey_q[`SRM_FKEY_OBJ1] && !vin_wr_any) |=>
      (vin_q != $past(vin_q)) ##1 ($stable(vin_q) || $past(vin_wr_any) || $past(key_rise[0])))
    else $error("Second key press did not toggle exactly once");

  AST_KEY2_OBJ: assert property ( // R6
    (key_rise[1] && fkey_q[`SRM_FKEY_OBJ1]) |=> obj_cmd[1] ##1 !obj_cmd[1])
    else $error("Second key object pulse missing or too long");

  AST_VIN_BUS: assert property ( // R2
    (bus_vin_wr.we && !panel_vin_wr.we && key_rise == 2'b00) |=>
      ((vin_q & $past(bus_vin_wr.mask)) == ($past(bus_vin_wr.value) & $past(bus_vin_wr.mask))))
    else $error("Comm bus write to virtual inputs lost");

  AST_VIN_PANEL: assert property ( // R2
    (panel_vin_wr.we && key_rise == 2'b00) |=>
      ((vin_q & $past(panel_vin_wr.mask)) == ($past(panel_vin_wr.value) & $past(panel_vin_wr.mask))))
    else $error("Panel write to virtual inputs lost");

  AST_DEST_SET: assert property ( // R7
    ##1 (($past(raw) & ~dest_q) == '0))
    else $error("Driven destination not set");
endmodule

// *** srm_far_side.sv ***
// Far-side model: protection stages, digital inputs and logic outputs feeding the matrix.
// Assumes the pclk domain; the bench asks for stage levels, this model registers them.
`timescale 1ns/1ns
module srm_far_side (
  input  wire logic        pclk,      // System clock
  input  wire logic        presetn,   // Async reset, active low
  input  wire logic [11:0] stage_set, // Requested stage levels
  output logic      [11:0] ext_src    // Stage levels into the matrix
);
  logic [11:0] src_q;
  logic [11:0] src_d;
  always_comb begin
    src_d = stage_set;
  end
  // Registered, like a real stage output, so levels never move on the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 12'h000;
    end else begin
      src_q <= src_d;
    end
  end
  assign ext_src = src_q;
endmodule

// *** signal_routing_matrix_with_latches_bench.sv ***
// Self-checking bench of the routing matrix: APB, routing, latches, keys, autoclear.
// Assumes srm_far_side as stage source and a 4-cycle millisecond tick.
`timescale 1ns/1ns
`include "srm_regs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module signal_routing_matrix_with_latches_bench;
  import srm_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rd_e, panel_release = 0;
  logic        first_function_key = 0, second_function_key = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_v;
  logic        pready, pslverr;
  logic [11:0] stage_set = '0, ext_src;
  srm_vin_wr_s panel_vin_wr = '0, bus_vin_wr = '0;
  srm_dest_s   dest;
  logic [3:0]  virtual_input, vin = '0, v;
  logic [1:0]  obj_cmd;
  logic [15:0] msk [22] = '{default: '0};
  logic [21:0] held = '0, latch = '0;
  int          checks = 0, err_total = 0, s, p;

  always #10 pclk = ~pclk;
  srm_far_side far (.pclk(pclk), .presetn(presetn), .stage_set(stage_set), .ext_src(ext_src));
  srm_matrix #(.MS_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_src(ext_src), .panel_vin_wr(panel_vin_wr), .bus_vin_wr(bus_vin_wr),
    .first_function_key(first_function_key), .second_function_key(second_function_key),
    .panel_release(panel_release), .dest(dest), .virtual_input(virtual_input), .obj_cmd(obj_cmd));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [21:0] raw(input logic [15:0] src);
    raw = '0;
    for (int d = 0; d < 22; d++)
      raw[d] = |(msk[d] & src);
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Looked at on the edge itself, so data is taken where pready is seen
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      err_total++;
      finish_test();
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stage levels pass the far side and the matrix: two edges before dest settles, the task waits three
  task automatic drive(input logic [11:0] lv);
    @(posedge pclk);
    stage_set <= lv;
    repeat (3) @(posedge pclk);
    #1;
    held = raw({lv, vin}) | (held & latch);
  endtask

  task automatic vwr(input int src, input logic [3:0] m, input logic [3:0] val);
    srm_vin_wr_s w;
    w = '{we: 1'b1, mask: m, value: val};
    @(posedge pclk);
    if (src == 0)
      panel_vin_wr <= w;
    else
      bus_vin_wr <= w;
    @(posedge pclk);
    panel_vin_wr <= '0;
    bus_vin_wr <= '0;
    vin = (vin & ~m) | (val & m);
  endtask

  // Key held six cycles so a level-sensitive toggle would show up
  task automatic press(input int k, output int pulses);
    pulses = 0;
    @(posedge pclk);
    if (k == 0)
      first_function_key <= 1'b1;
    else
      second_function_key <= 1'b1;
    repeat (6) begin
      @(posedge pclk);
      pulses += (obj_cmd[k] === 1'b1);
    end
    first_function_key <= 1'b0;
    second_function_key <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  initial begin
    void'($urandom(32'hfc87));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SRM_OFF_FKEY, 0);
    `CHK("fkey reset", 32'h10, rd_v)
    apb(0, `SRM_OFF_AUTO, 0);
    `CHK("auto reset", 32'h05DC_0000, rd_v)
    apb(0, 8'hFC, 0);
    `CHK("unmapped err", 1'b1, rd_e)
    for (int d = 0; d < 22; d++) begin
      s = 4 + $urandom % 12;
      msk[d] = 16'(1 << s);
      apb(1, `SRM_OFF_MTX + 8'(4 * d), 32'(msk[d]));
      drive(12'(1 << (s - 4)));
      `CHK("routed", held, dest)
      drive(12'h000);
      `CHK("follow", held, dest)
      msk[d] = 16'h0000;
      apb(1, `SRM_OFF_MTX + 8'(4 * d), 32'h0);
    end
    latch = 22'h3FFFFF;
    apb(1, `SRM_OFF_LATCH, 32'(latch));
    msk[0] = 16'h0010;
    msk[5] = 16'h0020;
    apb(1, `SRM_OFF_MTX, 32'h10);
    apb(1, `SRM_OFF_MTX + 8'd20, 32'h20);
    drive(12'h003);
    drive(12'h000);
    `CHK("latched", 22'h21, dest)
    apb(0, `SRM_OFF_STATE, 0);
    `CHK("state read", 32'h21, rd_v)
    apb(1, `SRM_OFF_RELEASE, 32'h1);
    drive(12'h000);
    held = raw({12'h0, vin});
    `CHK("sw release", held, dest)
    drive(12'h003);
    drive(12'h000);
    @(posedge pclk);
    panel_release <= 1'b1;
    @(posedge pclk);
    panel_release <= 1'b0;
    drive(12'h000);
    held = raw({12'h0, vin});
    `CHK("panel release", held, dest)
    latch = '0;
    msk[0] = '0;
    apb(1, `SRM_OFF_LATCH, 32'h0);
    apb(1, `SRM_OFF_MTX, 32'h0);
    for (int k = 0; k < 4; k++) begin
      msk[16 + k] = 16'(1 << k);
      apb(1, `SRM_OFF_MTX + 8'(4 * (16 + k)), 32'(msk[16 + k]));
    end
    v = 4'($urandom);
    apb(1, `SRM_OFF_VIN, 32'(v));
    vin = v;
    drive(12'h000);
    `CHK("vin sw", vin, virtual_input)
    `CHK("vout", held, dest)
    vwr(1, 4'hF, ~v);
    drive(12'h000);
    `CHK("vin bus", vin, virtual_input)
    vwr(0, 4'h5, v);
    drive(12'h000);
    `CHK("vin panel", held, dest)
    press(0, p);
    vin[0] = ~vin[0];
    `CHK("key one", vin, virtual_input)
    `CHK("key one no cmd", 0, p)
    press(1, p);
    vin[1] = ~vin[1];
    `CHK("key two", vin, virtual_input)
    apb(1, `SRM_OFF_FKEY, 32'h43);
    press(0, p);
    vin[3] = ~vin[3];
    `CHK("key remap", vin, virtual_input)
    press(1, p);
    `CHK("obj pulses", 1, p)
    `CHK("obj no toggle", vin, virtual_input)
    apb(1, `SRM_OFF_FKEY, 32'h34);
    press(0, p);
    `CHK("key one cmd", 1, p)
    press(1, p);
    vin[3] = ~vin[3];
    `CHK("key two remap", vin, virtual_input)
    latch = 22'h60;
    msk[6] = 16'h0040;
    apb(1, `SRM_OFF_LATCH, 32'h60);
    apb(1, `SRM_OFF_MTX + 8'd24, 32'h40);
    apb(1, `SRM_OFF_AUTO, 32'h0003_0001);
    drive(12'h002);
    drive(12'h000);
    repeat (40) @(posedge pclk);
    drive(12'h004);
    held[5] = 1'b0;
    `CHK("old led cleared", held, dest)
    drive(12'h000);
    drive(12'h002);
    `CHK("young led kept", held, dest)
    finish_test();
  end
endmodule
